// ### ldcl_pkg.sv
`default_nettype none
package ldcl_pkg;
	// Common shift register and latch geometry
	localparam int SR_W         = 769;
	localparam int SR_TOP       = 768;
	localparam int GRAY_LATCH_W = 768;
	localparam int CTRL_W       = 371;
	localparam int CORR_W       = 336;
	localparam int CH_N         = 48;
	localparam int GRAY_W       = 16;
	// Current range fields, three bits per colour group
	localparam int CR_W         = 3;
	localparam int CR_ALL_W     = 9;
	localparam int RED_CR_LSB   = 336;
	localparam int GREEN_CR_LSB = 339;
	localparam int BLUE_CR_LSB  = 342;
	localparam logic [2:0] CR_RESET = 3'h0;
	// Group brightness fields, seven bits per colour group
	localparam int BR_W         = 7;
	localparam int RED_BR_LSB   = 345;
	localparam int GREEN_BR_LSB = 352;
	localparam int BLUE_BR_LSB  = 359;
	localparam logic [6:0] BR_FULL = 7'h7f;
	// Function setting bits
	localparam int REPEAT_BIT   = 366;
	localparam int RESTART_BIT  = 367;
	localparam int DEFER_BIT    = 368;
	localparam int SPREAD_BIT   = 369;
	localparam int SHORT_THR_BIT = 370;
	localparam int SHORT_THR_LOW_PCT  = 70;
	localparam int SHORT_THR_HIGH_PCT = 90;
	// Fault status placement in the shift register
	localparam int SHORT_STATUS_LSB = 672;
	localparam int OPEN_STATUS_LSB  = 720;
	// Count clock timing
	localparam int PERIOD_CLOCKS     = 65536;
	localparam int OPEN_SAMPLE_CLOCK = 33;
	localparam int HOST_DEFER_WAIT   = 65538;
	localparam logic [15:0] LAST_COUNT  = 16'(PERIOD_CLOCKS - 1);
	localparam logic [15:0] OPEN_SAMPLE = 16'(OPEN_SAMPLE_CLOCK - 1);
	localparam int CLK_PERIOD_NS = 100;
endpackage
`default_nettype wire

// ### ldcl_pwm_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ldcl_pwm_if;
	import ldcl_pkg::*;
	logic                    tick;      // One count clock rising edge
	logic                    restart;   // Clear counter, force outputs off
	logic                    repeat_en; // Run periods back to back
	logic                    spread_en; // Spread-spectrum compare
	logic [GRAY_LATCH_W-1:0] gray_data; // Grayscale latch
	logic [GRAY_W-1:0]       count;     // Grayscale counter
	logic [CH_N-1:0]         chan_on;   // Output on states
	logic                    done;      // Single period finished
	modport core (input tick, restart, repeat_en, spread_en, gray_data,
		output count, chan_on, done);
	modport ctrl (output tick, restart, repeat_en, spread_en, gray_data,
		input count, chan_on, done);
endinterface
`default_nettype wire

// ### ldcl_pwm_core.sv
`timescale 1ns/1ns
`default_nettype none
module ldcl_pwm_core
	import ldcl_pkg::*;
(
	input  wire logic clk,
	input  wire logic arst_n,
	ldcl_pwm_if.core  bus
);
	logic [GRAY_W-1:0] count_reg; // Grayscale counter
	logic              off_reg;   // Outputs forced off
	logic              done_reg;  // Period over, no repeat
	logic [CH_N-1:0]   on_reg;    // Registered on states
	logic [CH_N-1:0]   on_next;   // Compare results
	logic [GRAY_W-1:0] cmp_val;   // Counter as compared

	// Reverse bit order, spreads on time over the period
	function automatic logic [GRAY_W-1:0] rev16(input logic [GRAY_W-1:0] v);
		logic [GRAY_W-1:0] r;
		r = '0;
		for (int k = 0; k < GRAY_W; k++) begin
			r[k] = v[GRAY_W-1-k];
		end
		return r;
	endfunction

	// Counter, cleared by restart, advanced per count clock until a single period ends
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= 16'h0000;
		end else if (bus.restart) begin
			count_reg <= 16'h0000;
		end else if (bus.tick && !done_reg) begin
			count_reg <= count_reg + 16'h0001;
		end
	end

	// Single period end when repeat is off
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			done_reg <= 1'b0;
		end else if (bus.restart) begin
			done_reg <= 1'b0;
		end else if (bus.tick && count_reg == LAST_COUNT && !bus.repeat_en) begin
			done_reg <= 1'b1;
		end
	end

	// Forced off until the next count clock edge
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			off_reg <= 1'b0;
		end else if (bus.restart) begin
			off_reg <= 1'b1;
		end else if (bus.tick) begin
			off_reg <= 1'b0;
		end
	end

	// Conventional or spread compare
	assign cmp_val = bus.spread_en ? rev16(count_reg) : count_reg;

	// One comparator per output
	generate
		for (genvar i = 0; i < CH_N; i++) begin : g_ch
			assign on_next[i] = !off_reg && !done_reg && (cmp_val < bus.gray_data[i*GRAY_W +: GRAY_W]);
		end
	endgenerate

	// Registered output states
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			on_reg <= '0;
		end else begin
			on_reg <= on_next;
		end
	end

	assign bus.count   = count_reg;
	assign bus.chan_on = on_reg;
	assign bus.done    = done_reg;
endmodule // ldcl_pwm_core
`default_nettype wire

// ### ldcl_latch_status.sv
// How it works
// - Current range changes only after matching double write
// - Current range fields reset to zero
// - Current range fields taken from bits 336-344
// - Full codes give full selected group current
// - Brightness fields taken from bits 345-365
// - Repeat bit selects single or repeating periods
// - Restart bit clears counter, forces outputs off
// - Outputs resume at next count clock edge
// - Direct mode copies latches at strobe rise
// - Deferred mode copies at 65536th count clock
// - Style bit picks conventional or spread PWM
// - Threshold bit selects 70 or 90 percent
// - Direct mode loads status at strobe fall
// - Top bit one never loads status
// - Deferred mode loads status at counter zero
// - Status load blocked until a bit shifts
// - Rewriting same grayscale refreshes status; restart bit still restarts counter
// - Status shifts out one bit per shift clock rise
// - Top bit one loads control latch
// - Open faults captured at 33rd count clock
`timescale 1ns/1ns
`default_nettype none
module ldcl_latch_status
	import ldcl_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               arst_n,
	input  wire logic               shift_clock_pin,
	input  wire logic               serial_in_pin,
	input  wire logic               load_strobe,
	input  wire logic               pwm_count_clock,
	input  wire logic [CH_N-1:0]    open_fault_raw,
	input  wire logic [CH_N-1:0]    short_fault_raw,
	output logic                    serial_out_pin,
	output logic [CH_N-1:0]         channel_on,
	output logic [GRAY_W-1:0]       grayscale_count,
	output logic [CR_W-1:0]         red_current_range,
	output logic [CR_W-1:0]         green_current_range,
	output logic [CR_W-1:0]         blue_current_range,
	output logic [BR_W-1:0]         red_group_brightness,
	output logic [BR_W-1:0]         green_group_brightness,
	output logic [BR_W-1:0]         blue_group_brightness,
	output logic [CORR_W-1:0]       per_channel_correction,
	output logic                    repeat_display_enable,
	output logic                    counter_restart_on_load,
	output logic                    deferred_update_enable,
	output logic                    spread_pwm_enable,
	output logic                    short_threshold_select
);
	// Pin synchronisers: shift clock, data, strobe, count clock
	logic [3:0]        pin_meta_reg;   // First stage
	logic [3:0]        pin_sync_reg;   // Second stage
	logic [3:0]        pin_prev_reg;   // Edge history
	logic [2*CH_N-1:0] fault_meta_reg; // Comparator first stage
	logic [2*CH_N-1:0] fault_sync_reg; // Comparator second stage

	// Decoded pin events
	logic shift_rise;  // Shift clock rising
	logic strobe_rise; // Strobe rising
	logic strobe_fall; // Strobe falling
	logic tick;        // Count clock rising
	logic sin_s;       // Synchronised data

	// Shift register and latches
	logic [SR_W-1:0]         sr_reg;         // Common shift register
	logic [CTRL_W-1:0]       ctrl_reg;       // Control latch
	logic [CR_ALL_W-1:0]     cr_reg;         // Applied current ranges
	logic [CR_ALL_W-1:0]     cand_reg;       // Last written current ranges
	logic                    cand_ok_reg;    // Candidate holds a write
	logic [GRAY_LATCH_W-1:0] gray_latch_reg; // Grayscale latch
	logic [GRAY_LATCH_W-1:0] gray_stage_reg; // Grayscale held for deferral
	logic [CORR_W-1:0]       corr_reg;       // Correction latch

	// Update sequencing
	logic        pend_reg;      // Deferred copy waiting
	logic [15:0] since_reg;     // Count clocks since strobe
	logic        fall_arm_reg;  // Status load at strobe fall
	logic        zero_wait_reg; // Status load at counter zero
	logic        block_reg;     // Status loaded, not yet shifted
	logic [CH_N-1:0] open_latch_reg;  // Open fault latch
	logic [CH_N-1:0] short_latch_reg; // Short fault latch

	// Combinational decodes
	logic sr_top;       // Top bit of shift register
	logic gray_write;   // Grayscale strobe
	logic ctrl_write;   // Control strobe
	logic defer_en;     // Deferred update mode
	logic cr_match;     // Double write detected
	logic direct_copy;  // Copy at strobe
	logic defer_copy;   // Copy at 65536th clock
	logic load_status;  // Fault status into shift register
	logic [CR_ALL_W-1:0] cr_field; // Current ranges in shift register

	ldcl_pwm_if pi ();

	// Two-flop synchronisers with edge history
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_meta_reg <= 4'h0;
			pin_sync_reg <= 4'h0;
			pin_prev_reg <= 4'h0;
		end else begin
			pin_meta_reg <= {pwm_count_clock, load_strobe, serial_in_pin, shift_clock_pin};
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg;
		end
	end

	// Fault comparator synchronisers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fault_meta_reg <= '0;
			fault_sync_reg <= '0;
		end else begin
			fault_meta_reg <= {short_fault_raw, open_fault_raw};
			fault_sync_reg <= fault_meta_reg;
		end
	end

	// Edge detection on second stage only
	assign shift_rise  = pin_sync_reg[0] && !pin_prev_reg[0];
	assign sin_s       = pin_sync_reg[1];
	assign strobe_rise = pin_sync_reg[2] && !pin_prev_reg[2];
	assign strobe_fall = !pin_sync_reg[2] && pin_prev_reg[2];
	assign tick        = pin_sync_reg[3] && !pin_prev_reg[3];

	// Strobe kind decided by top bit
	assign sr_top     = sr_reg[SR_TOP];
	assign gray_write = strobe_rise && !sr_top;
	assign ctrl_write = strobe_rise && sr_top;
	assign defer_en   = ctrl_reg[DEFER_BIT];
	assign cr_field   = sr_reg[RED_CR_LSB +: CR_ALL_W];
	assign cr_match   = cand_ok_reg && (cr_field == cand_reg);

	// Control latch load from low shift register bits
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= '0;
		end else if (ctrl_write) begin
			ctrl_reg <= sr_reg[CTRL_W-1:0];
		end
	end

	// Current ranges need the same value twice running
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cr_reg      <= {CR_RESET, CR_RESET, CR_RESET};
			cand_reg    <= '0;
			cand_ok_reg <= 1'b0;
		end else if (ctrl_write) begin
			cand_reg    <= cr_field;
			cand_ok_reg <= 1'b1;
			if (cr_match) begin
				cr_reg <= cr_field;
			end
		end
	end

	// Copy timing for grayscale and correction latches
	assign direct_copy = gray_write && !defer_en;
	assign defer_copy  = pend_reg && tick && since_reg == LAST_COUNT;

	// Deferred copy waits a full period of count clocks
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pend_reg  <= 1'b0;
			since_reg <= 16'h0000;
		end else if (gray_write && defer_en) begin
			pend_reg  <= 1'b1;
			since_reg <= 16'h0000;
		end else if (defer_copy) begin
			pend_reg  <= 1'b0;
		end else if (pend_reg && tick) begin
			since_reg <= since_reg + 16'h0001;
		end
	end

	// Grayscale held at strobe so later status loads do not leak in
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			gray_stage_reg <= '0;
		end else if (gray_write) begin
			gray_stage_reg <= sr_reg[GRAY_LATCH_W-1:0];
		end
	end

	// Grayscale and correction latches
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			gray_latch_reg <= '0;
			corr_reg       <= '0;
		end else if (direct_copy) begin
			gray_latch_reg <= sr_reg[GRAY_LATCH_W-1:0];
			corr_reg       <= ctrl_reg[CORR_W-1:0];
		end else if (defer_copy) begin
			gray_latch_reg <= gray_stage_reg;
			corr_reg     <= ctrl_reg[CORR_W-1:0];
		end
	end

	// Status load arming per update mode
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fall_arm_reg  <= 1'b0;
			zero_wait_reg <= 1'b0;
		end else if (ctrl_write) begin
			fall_arm_reg  <= 1'b0;
			zero_wait_reg <= 1'b0;
		end else if (gray_write) begin
			fall_arm_reg  <= !defer_en;
			zero_wait_reg <= defer_en;
		end else begin
			if (strobe_fall) begin
				fall_arm_reg <= 1'b0;
			end
			if (tick && pi.count == 16'h0000) begin
				zero_wait_reg <= 1'b0;
			end
		end
	end

	// Status load, refused while a load is unshifted
	assign load_status = !block_reg && (
		(fall_arm_reg && strobe_fall) ||
		(zero_wait_reg && tick && pi.count == 16'h0000));

	// Block flag; a new load wins over the shift clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			block_reg <= 1'b0;
		end else if (load_status) begin
			block_reg <= 1'b1;
		end else if (shift_rise) begin
			block_reg <= 1'b0;
		end
	end

	// Shift register: status load or shift in at low end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sr_reg <= '0;
		end else if (load_status) begin
			sr_reg[SHORT_STATUS_LSB +: CH_N] <= short_latch_reg;
			sr_reg[OPEN_STATUS_LSB +: CH_N]  <= open_latch_reg;
		end else if (shift_rise) begin
			sr_reg <= {sr_reg[SR_W-2:0], sin_s};
		end
	end

	// Fault latch at the 33rd count clock; off outputs read zero open status, short status unmasked
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			open_latch_reg  <= '0;
			short_latch_reg <= '0;
		end else if (tick && pi.count == OPEN_SAMPLE) begin
			open_latch_reg  <= fault_sync_reg[CH_N-1:0] & pi.chan_on;
			short_latch_reg <= fault_sync_reg[2*CH_N-1:CH_N];
		end
	end

	// Counter and compare core hookup
	assign pi.tick      = tick;
	assign pi.restart   = gray_write && ctrl_reg[RESTART_BIT];
	assign pi.repeat_en = ctrl_reg[REPEAT_BIT];
	assign pi.spread_en = ctrl_reg[SPREAD_BIT];
	assign pi.gray_data = gray_latch_reg;

	ldcl_pwm_core u_core (
		.clk    (clk),
		.arst_n (arst_n),
		.bus    (pi.core)
	);

	// Field outputs; full codes give the selected group current
	assign red_current_range      = cr_reg[0 +: CR_W];
	assign green_current_range    = cr_reg[CR_W +: CR_W];
	assign blue_current_range     = cr_reg[2*CR_W +: CR_W];
	assign red_group_brightness   = ctrl_reg[RED_BR_LSB +: BR_W];
	assign green_group_brightness = ctrl_reg[GREEN_BR_LSB +: BR_W];
	assign blue_group_brightness  = ctrl_reg[BLUE_BR_LSB +: BR_W];
	assign per_channel_correction = corr_reg;
	assign repeat_display_enable  = ctrl_reg[REPEAT_BIT];
	assign counter_restart_on_load = ctrl_reg[RESTART_BIT];
	assign deferred_update_enable = ctrl_reg[DEFER_BIT];
	assign spread_pwm_enable      = ctrl_reg[SPREAD_BIT];
	assign short_threshold_select = ctrl_reg[SHORT_THR_BIT];
	assign serial_out_pin         = sr_reg[SR_TOP];
	assign channel_on             = pi.chan_on;
	assign grayscale_count        = pi.count;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_cr_single_write: assert property (
		ctrl_write && !cr_match |=> $stable(cr_reg))
		else $error("current range changed on single write");

	a_cr_double_write: assert property (
		ctrl_write && cr_match |=> red_current_range == $past(sr_reg[RED_CR_LSB +: CR_W]))
		else $error("red current range not from its bits");

	a_bright_load: assert property (
		ctrl_write |=> blue_group_brightness == $past(sr_reg[BLUE_BR_LSB +: BR_W]))
		else $error("blue brightness not from its bits");

	a_restart_clear: assert property (
		gray_write && ctrl_reg[RESTART_BIT] |=> pi.count == 16'h0000 ##1 channel_on == '0)
		else $error("restart did not clear counter and outputs");

	a_single_period: assert property (
		pi.done |=> channel_on == '0)
		else $error("output on after single period");

	a_direct_copy: assert property (
		gray_write && !defer_en |=> gray_latch_reg == $past(sr_reg[GRAY_LATCH_W-1:0]))
		else $error("grayscale latch missed direct copy");

	a_ctrl_no_status: assert property (
		ctrl_write |=> !fall_arm_reg && !zero_wait_reg)
		else $error("control write armed a status load");

	a_status_block: assert property (
		load_status |=> block_reg && !load_status)
		else $error("status load not blocked");

	a_shift_out: assert property (
		shift_rise && !load_status |=> serial_out_pin == $past(sr_reg[SR_TOP-1]))
		else $error("serial out did not advance");

	a_open_capture: assert property (
		tick && pi.count == OPEN_SAMPLE |=>
		open_latch_reg == ($past(fault_sync_reg[CH_N-1:0]) & $past(pi.chan_on)))
		else $error("open fault latch wrong");

	c_ctrl_write:  cover property (ctrl_write && cr_match);
	c_direct_stat: cover property (fall_arm_reg && strobe_fall && !block_reg);
	c_defer_copy:  cover property (defer_copy);
	c_defer_stat:  cover property (zero_wait_reg && tick && pi.count == 16'h0000);
endmodule // ldcl_latch_status
`default_nettype wire

// ### ldcl_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module ldcl_host_model
	import ldcl_pkg::*;
(
	input  wire logic clk,             // Bench clock, paces the pins
	output var  logic shift_clock_pin, // Serial shift clock
	output var  logic serial_in_pin,   // Serial data
	output var  logic load_strobe,     // Load strobe
	output var  logic pwm_count_clock  // Grayscale count clock
);
	// Idle: clocks and strobe low, still outside frames
	initial begin
		shift_clock_pin = 1'b0;
		serial_in_pin   = 1'b0;
		load_strobe     = 1'b0;
		pwm_count_clock = 1'b0;
	end

	// Wait n falling edges of the bench clock
	task automatic pace(input int n);
		repeat (n) @(negedge clk);
	endtask

	// One 800 ns bit; data inverted once its hold has run out
	task automatic shift_bit(input logic b);
		serial_in_pin = b;
		pace(2);
		shift_clock_pin = 1'b1;
		pace(4);
		shift_clock_pin = 1'b0;
		serial_in_pin = ~b;
		pace(2);
	endtask

	// Whole 769-bit word, top bit first so it ends up at the top
	task automatic send_word(input logic [SR_W-1:0] w);
		for (int i = SR_TOP; i >= 0; i--) begin
			shift_bit(w[i]);
		end
	endtask

	// Strobe pulse, then time for the status load to land
	task automatic pulse_strobe();
		load_strobe = 1'b1;
		pace(4);
		load_strobe = 1'b0;
		pace(6);
	endtask

	// Burst of count clock periods
	task automatic tick(input int n);
		repeat (n) begin
			pwm_count_clock = 1'b1;
			pace(4);
			pwm_count_clock = 1'b0;
			pace(4);
		end
	endtask
endmodule // ldcl_host_model
`default_nettype wire

// ### test_led_driver_control_latch_and_status.sv
`timescale 1ns/1ns
`default_nettype none
module test_led_driver_control_latch_and_status;
	import ldcl_pkg::*;
	logic clk, arst_n, sck, sdi, strobe, cclk, sdo; // Bench wires
	logic [CH_N-1:0]   open_raw, short_raw, ch_on;  // Fault inputs, outputs
	logic [GRAY_W-1:0] count;                       // Grayscale counter
	logic [CR_W-1:0]   cr_r, cr_g, cr_b;            // Applied ranges
	logic [BR_W-1:0]   br_r, br_g, br_b;            // Brightness fields
	logic [CORR_W-1:0] corr;                        // Correction latch
	logic [4:0]        fbits;                       // Function bits
	logic [SR_W-1:0]   gray_word;                   // All channels full scale
	int err_count;                                   // Mismatches
	int checked;                                     // Comparisons

	ldcl_latch_status i_ldcl_latch_status (.clk(clk), .arst_n(arst_n),
		.shift_clock_pin(sck), .serial_in_pin(sdi), .load_strobe(strobe),
		.pwm_count_clock(cclk), .open_fault_raw(open_raw), .short_fault_raw(short_raw),
		.serial_out_pin(sdo), .channel_on(ch_on), .grayscale_count(count),
		.red_current_range(cr_r), .green_current_range(cr_g), .blue_current_range(cr_b),
		.red_group_brightness(br_r), .green_group_brightness(br_g),
		.blue_group_brightness(br_b), .per_channel_correction(corr),
		.repeat_display_enable(fbits[0]), .counter_restart_on_load(fbits[1]),
		.deferred_update_enable(fbits[2]), .spread_pwm_enable(fbits[3]),
		.short_threshold_select(fbits[4]));

	ldcl_host_model i_ldcl_host_model (.clk(clk), .shift_clock_pin(sck),
		.serial_in_pin(sdi), .load_strobe(strobe), .pwm_count_clock(cclk));

	// Bench clock
	always #(CLK_PERIOD_NS/2) clk = ~clk;

	// Count a comparison, report a mismatch
	task automatic check(input logic [CORR_W-1:0] got, input logic [CORR_W-1:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Control word: given ranges and function bits, fixed brightness
	function automatic logic [SR_W-1:0] ctrl_word(input logic [CR_ALL_W-1:0] cr,
		input logic [4:0] fb);
		logic [SR_W-1:0] w;
		w = '0;
		w[SR_TOP] = 1'b1;
		w[CORR_W-1:0] = {42{8'h5a}};
		w[RED_CR_LSB +: CR_ALL_W] = cr;
		w[RED_BR_LSB +: BR_W] = BR_FULL;
		w[GREEN_BR_LSB +: BR_W] = 7'h2a;
		w[BLUE_BR_LSB +: BR_W] = 7'h55;
		w[REPEAT_BIT +: 5] = fb;
		return w;
	endfunction

	// Control write with its strobe
	task automatic write_ctrl(input logic [CR_ALL_W-1:0] cr, input logic [4:0] fb);
		i_ldcl_host_model.send_word(ctrl_word(cr, fb));
		i_ldcl_host_model.pulse_strobe();
	endtask

	// Top bit, then 48 open and 48 short flags, one per shift
	task automatic read_status(input logic [CH_N-1:0] op, input logic [CH_N-1:0] sh);
		check(sdo, 1'b0);
		for (int k = 1; k <= 2*CH_N; k++) begin
			i_ldcl_host_model.shift_bit(1'b0);
			check(sdo, (k <= CH_N) ? op[CH_N-k] : sh[2*CH_N-k]);
		end
	endtask

	// Ranges at zero straight out of reset
	task automatic t_reset();
		check({cr_b, cr_g, cr_r}, 9'h0);
		check(sdo, 1'b0);
	endtask

	// Ranges need two equal writes; other fields follow each write
	task automatic t_control();
		write_ctrl(9'h1d5, 5'h13);
		check({cr_b, cr_g, cr_r}, 9'h0);
		check({br_b, br_g, br_r}, {7'h55, 7'h2a, BR_FULL});
		check(fbits, 5'h13);
		write_ctrl(9'h1d5, 5'h13);
		check(cr_r, 3'h5);
		check(cr_g, 3'h2);
		check(cr_b, 3'h7);
	endtask

	// Direct grayscale load, counting, blocked status reload
	task automatic t_grayscale();
		i_ldcl_host_model.tick(2);
		check(count, 16'd2);
		i_ldcl_host_model.send_word(gray_word);
		i_ldcl_host_model.pulse_strobe();
		check(count, 16'h0);
		check(corr, {42{8'h5a}});
		open_raw = 48'h9234_5678_9abc;
		short_raw = 48'h8421_00ff_f00f;
		i_ldcl_host_model.tick(40);
		check(count, 16'd40);
		check(ch_on, {CH_N{1'b1}});
		i_ldcl_host_model.pulse_strobe();
		read_status('0, '0);
	endtask

	// Control write loads no status; rewrite refreshes status
	task automatic t_refresh();
		write_ctrl(9'h0e1, 5'h13);
		check({cr_b, cr_g, cr_r}, 9'h1d5);
		check(sdo, 1'b1);
		i_ldcl_host_model.shift_bit(1'b0);
		check(sdo, 1'b0);
		i_ldcl_host_model.tick(3);
		check(count, 16'd3);
		i_ldcl_host_model.send_word(gray_word);
		i_ldcl_host_model.pulse_strobe();
		check(count, 16'h0);
		check(ch_on, '0);
		read_status(48'h9234_5678_9abc, 48'h8421_00ff_f00f);
	endtask

	// Deferred mode: matching range write, no copy at strobe, old grayscale kept
	task automatic t_deferred();
		write_ctrl(9'h0e1, 5'h06);
		check({cr_b, cr_g, cr_r}, 9'h0e1);
		check(fbits, 5'h06);
		i_ldcl_host_model.tick(2);
		check(ch_on, {CH_N{1'b1}});
		i_ldcl_host_model.send_word('0);
		i_ldcl_host_model.pulse_strobe();
		check(count, 16'h0);
		i_ldcl_host_model.tick(3);
		check(count, 16'd3);
		check(ch_on, {CH_N{1'b1}});
	endtask

	// Verdict and end of run
	task automatic test_done();
		$display("checked=%0d err_count=%0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		open_raw = '0;
		short_raw = '0;
		err_count = 0;
		checked = 0;
		gray_word = '0;
		gray_word[GRAY_LATCH_W-1:0] = '1;
		repeat (2) @(negedge clk);
		arst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_reset();
		t_control();
		t_grayscale();
		t_refresh();
		t_deferred();
		test_done();
	end

	// Hang guard
	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		test_done();
	end
endmodule // test_led_driver_control_latch_and_status
`default_nettype wire
